/* File: src/cstk_pkg.sv */
package cstk_pkg;
   // Special-function register addresses in data memory
   localparam logic [11:0] ADDR_INDIRECT_ACCESS_PTR1      = 12'hFE7;
   localparam logic [11:0] ADDR_WORKING_REGISTER       = 12'hFE8;
   localparam logic [11:0] ADDR_PTR0_LOW   = 12'hFE9;
   localparam logic [11:0] ADDR_PTR0_HIGH  = 12'hFEA;
   localparam logic [11:0] ADDR_INDIRECT_OFFSET_BY_W_0     = 12'hFEB;
   localparam logic [11:0] ADDR_INDIRECT_PRE_INCREMENT_0    = 12'hFEC;
   localparam logic [11:0] ADDR_INDIRECT_POST_DECREMENT_0   = 12'hFED;
   localparam logic [11:0] ADDR_INDIRECT_POST_INCREMENT_0   = 12'hFEE;
   localparam logic [11:0] ADDR_INDIRECT_ACCESS_PTR0      = 12'hFEF;
   localparam logic [11:0] ADDR_INTCTL3    = 12'hFF0;
   localparam logic [11:0] ADDR_INTCTL2    = 12'hFF1;
   localparam logic [11:0] ADDR_INTCTL1    = 12'hFF2;
   localparam logic [11:0] ADDR_PROD_LOW   = 12'hFF3;
   localparam logic [11:0] ADDR_PROD_HIGH  = 12'hFF4;
   localparam logic [11:0] ADDR_TBL_LATCH  = 12'hFF5;
   localparam logic [11:0] ADDR_TBL_LOW    = 12'hFF6;
   localparam logic [11:0] ADDR_TBL_HIGH   = 12'hFF7;
   localparam logic [11:0] ADDR_TBL_UPPER  = 12'hFF8;
   localparam logic [11:0] ADDR_PC_LOW     = 12'hFF9;
   localparam logic [11:0] ADDR_PC_HOLD_H  = 12'hFFA;
   localparam logic [11:0] ADDR_PC_HOLD_U  = 12'hFFB;
   localparam logic [11:0] ADDR_STK_PTR    = 12'hFFC;
   localparam logic [11:0] ADDR_TOS_LOW    = 12'hFFD;
   localparam logic [11:0] ADDR_TOS_HIGH   = 12'hFFE;
   localparam logic [11:0] ADDR_TOS_UPPER  = 12'hFFF;
   // Banked-only window outside the access bank
   localparam logic [11:0] ADDR_BANKED_LO  = 12'hF16;
   localparam logic [11:0] ADDR_BANKED_HI  = 12'hF5F;
   localparam logic [3:0]  BANKED_BANK     = 4'hF;

   // Field positions
   localparam int STK_FULL_BIT  = 7;
   localparam int STK_UNF_BIT   = 6;
   localparam int STK_PTR_W     = 5;
   localparam int TBL_BIT21     = 5;
   localparam int PC_W          = 21;
   localparam int TBL_W         = 22;
   localparam int STK_DEPTH     = 31;
   localparam logic [4:0] STK_TOP = 5'h1F;

   // Reset values
   localparam logic [7:0] RST_INTCTL3 = 8'hC0;
   localparam logic [7:0] RST_INTCTL2 = 8'hFF;
   localparam logic [7:0] RST_ZERO    = 8'h00;

   // Core operation codes presented by the sequencer
   localparam logic [3:0] OP_NONE      = 4'h0;
   localparam logic [3:0] OP_CALL      = 4'h1;
   localparam logic [3:0] OP_CALL_FAST = 4'h2;
   localparam logic [3:0] OP_RET       = 4'h3;
   localparam logic [3:0] OP_RET_FAST  = 4'h4;
   localparam logic [3:0] OP_RETURN_FROM_INTERRUPT    = 4'h5;
   localparam logic [3:0] OP_RETURN_FROM_INTERRUPT_F  = 4'h6;
   localparam logic [3:0] OP_RET_LIT   = 4'h7;
   localparam logic [3:0] OP_ADD_W_PCL = 4'h8;
   localparam logic [3:0] OP_TBL_READ  = 4'h9;
   localparam logic [3:0] OP_VECTOR    = 4'hA;
   localparam logic [3:0] OP_STEP      = 4'hB;

   typedef enum logic [2:0] {
      CSTK_RUN  = 3'b001,
      CSTK_TRIP = 3'b010,
      CSTK_RST  = 3'b100
   } cstk_state_t;
endpackage : cstk_pkg

/* File: src/cstk_core.sv */
// How it works
// - Enabled overflow reset: set flag, then reset
// - Disabled: flag only, no reset
// - Flags clear only by software or power-on
// - One-entry hidden shadow of status, W, bank
// - Interrupt vector copies registers into shadow
// - Fast interrupt return restores from shadow
// - High-priority entry overwrites shadow contents
// - Fast call saves, fast return restores
// - W added to PC low advances bytes
// - Literal return loads W and returns
// - Computed table uses one stack entry
// - Table read moves one byte to latch
// - Top of stack as three bytes
// - PC low mapped; write moves PC
// - Offset indirect reads pointer0 plus signed W
// - Banked window needs bank select loaded
// - Unimplemented bits read as zero
module cstk_core (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        en_i,
   input  wire logic        por_i,
   input  wire logic        stack_overflow_reset_enable_i,
   input  wire logic [3:0]  op_i,
   input  wire logic [7:0]  literal_i,
   input  wire logic [20:0] target_i,
   input  wire logic [7:0]  status_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic        access_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic [15:0] pmem_word_i,
   output logic [7:0]       rdata_o,
   output logic [20:0]      pc_o,
   output logic [21:0]      pmem_addr_o,
   output logic [7:0]       status_o,
   output logic             status_load_o,
   output logic [11:0]      data_addr_o,
   output logic             device_reset_o
);
   logic [7:0]          working_register;
   logic [3:0]          bank_select_register;
   logic [7:0]          shadow_status;
   logic [7:0]          shadow_w;
   logic [3:0]          shadow_bank;
   logic [20:0]         pc;
   logic [7:0]          pc_high_holding;
   logic [4:0]          pc_upper_holding;
   logic [21:0]         table_pointer;
   logic [7:0]          table_latch;
   logic [11:0]         data_pointer0;
   logic [7:0]          intctl [3];
   logic [7:0]          prod [2];
   logic [4:0]          return_stack_pointer;
   logic                stack_full_flag;
   logic                stack_underflow_flag;
   logic [20:0]         stack_mem [cstk_pkg::STK_DEPTH];
   cstk_pkg::cstk_state_t state;
   logic [11:0]         full_addr;
   logic                sel_wr;
   logic                push;
   logic                pop;
   logic                overflow_ev;
   logic                underflow_ev;
   logic [20:0]         top_of_stack;
   logic [11:0]         next_data_addr;
   logic [7:0]          next_rdata;

   // Access bank: low part in bank 0, high part in bank 15, so the
   // banked-only window is reachable only through the bank select
   // banked window
   assign full_addr = !access_i ? {bank_select_register, addr_i}
                    : (addr_i > cstk_pkg::ADDR_BANKED_HI[7:0]) ? {cstk_pkg::BANKED_BANK, addr_i}
                    : {4'h0, addr_i};
   assign sel_wr    = wr_i && en_i && (state == cstk_pkg::CSTK_RUN);

   assign push = (op_i == cstk_pkg::OP_CALL) || (op_i == cstk_pkg::OP_CALL_FAST)
              || (op_i == cstk_pkg::OP_VECTOR);
   assign pop  = (op_i == cstk_pkg::OP_RET) || (op_i == cstk_pkg::OP_RET_FAST)
              || (op_i == cstk_pkg::OP_RETURN_FROM_INTERRUPT) || (op_i == cstk_pkg::OP_RETURN_FROM_INTERRUPT_F)
              || (op_i == cstk_pkg::OP_RET_LIT);
   assign overflow_ev  = push && (return_stack_pointer == cstk_pkg::STK_TOP);
   assign underflow_ev = pop && (return_stack_pointer == 5'h00);
   assign top_of_stack = (return_stack_pointer == 5'h00) ? 21'h000000
              : stack_mem[return_stack_pointer - 5'h01];

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state <= cstk_pkg::CSTK_RUN;
      end else if (en_i) begin
         case (state)
            cstk_pkg::CSTK_RUN: begin
               if ((overflow_ev || underflow_ev) && stack_overflow_reset_enable_i) begin
                  state <= cstk_pkg::CSTK_TRIP;
               end
            end
            cstk_pkg::CSTK_TRIP: state <= cstk_pkg::CSTK_RST;
            cstk_pkg::CSTK_RST:  state <= cstk_pkg::CSTK_RUN;
            default:             state <= cstk_pkg::CSTK_RUN;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         device_reset_o <= 1'b0;
      end else if (en_i) begin
         device_reset_o <= (state == cstk_pkg::CSTK_TRIP);
      end
   end

   // Flags survive the stack-trip reset; only power-on or a software write clears them
   // sticky flags
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         stack_full_flag      <= 1'b0;
         stack_underflow_flag <= 1'b0;
      end else if (en_i && state == cstk_pkg::CSTK_RUN) begin
         if (overflow_ev) begin
            stack_full_flag <= 1'b1;
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_STK_PTR
                      && !wdata_i[cstk_pkg::STK_FULL_BIT]) begin
            stack_full_flag <= 1'b0;
         end
         if (underflow_ev) begin
            stack_underflow_flag <= 1'b1;
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_STK_PTR
                      && !wdata_i[cstk_pkg::STK_UNF_BIT]) begin
            stack_underflow_flag <= 1'b0;
         end
      end
   end

   // Return stack and pointer
   always_ff @(posedge clk_i) begin
      if (!nrst_i || state == cstk_pkg::CSTK_RST) begin
         return_stack_pointer <= 5'h00;
      end else if (en_i && state == cstk_pkg::CSTK_RUN) begin
         if (push && !overflow_ev) begin
            stack_mem[return_stack_pointer] <= pc + 21'h000002;
            return_stack_pointer <= return_stack_pointer + 5'h01;
         end else if (pop && !underflow_ev) begin
            return_stack_pointer <= return_stack_pointer - 5'h01;
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_STK_PTR) begin
            return_stack_pointer <= wdata_i[cstk_pkg::STK_PTR_W-1:0];
         end else if (sel_wr && return_stack_pointer != 5'h00) begin
            if (full_addr == cstk_pkg::ADDR_TOS_LOW) begin
               stack_mem[return_stack_pointer - 5'h01][7:0] <= wdata_i;
            end else if (full_addr == cstk_pkg::ADDR_TOS_HIGH) begin
               stack_mem[return_stack_pointer - 5'h01][15:8] <= wdata_i;
            end else if (full_addr == cstk_pkg::ADDR_TOS_UPPER) begin
               stack_mem[return_stack_pointer - 5'h01][20:16] <= wdata_i[4:0];
            end
         end
      end
   end

   // Program counter
   always_ff @(posedge clk_i) begin
      if (!nrst_i || state == cstk_pkg::CSTK_RST) begin
         pc <= 21'h000000;
      end else if (en_i && state == cstk_pkg::CSTK_RUN) begin
         case (op_i)
            cstk_pkg::OP_CALL, cstk_pkg::OP_CALL_FAST, cstk_pkg::OP_VECTOR: begin
               pc <= target_i;
            end
            cstk_pkg::OP_RET, cstk_pkg::OP_RET_FAST, cstk_pkg::OP_RETURN_FROM_INTERRUPT,
            cstk_pkg::OP_RETURN_FROM_INTERRUPT_F, cstk_pkg::OP_RET_LIT: begin
               pc <= top_of_stack;
            end
            cstk_pkg::OP_ADD_W_PCL: begin
               pc <= {pc_upper_holding, pc_high_holding, pc[7:0] + working_register};
            end
            cstk_pkg::OP_STEP: pc <= pc + 21'h000002;
            default: begin
               if (sel_wr && full_addr == cstk_pkg::ADDR_PC_LOW) begin
                  pc <= {pc_upper_holding, pc_high_holding, wdata_i};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pc_high_holding  <= cstk_pkg::RST_ZERO;
         pc_upper_holding <= 5'h00;
      end else if (sel_wr) begin
         if (full_addr == cstk_pkg::ADDR_PC_HOLD_H) begin
            pc_high_holding <= wdata_i;
         end
         if (full_addr == cstk_pkg::ADDR_PC_HOLD_U) begin
            pc_upper_holding <= wdata_i[4:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         shadow_status <= cstk_pkg::RST_ZERO;
         shadow_w      <= cstk_pkg::RST_ZERO;
         shadow_bank   <= 4'h0;
      end else if (en_i && state == cstk_pkg::CSTK_RUN) begin
         if (op_i == cstk_pkg::OP_VECTOR || op_i == cstk_pkg::OP_CALL_FAST) begin
            shadow_status <= status_i;
            shadow_w      <= working_register;
            shadow_bank   <= bank_select_register;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         working_register     <= cstk_pkg::RST_ZERO;
         bank_select_register <= 4'h0;
      end else if (en_i && state == cstk_pkg::CSTK_RUN) begin
         if (op_i == cstk_pkg::OP_RETURN_FROM_INTERRUPT_F || op_i == cstk_pkg::OP_RET_FAST) begin
            working_register     <= shadow_w;
            bank_select_register <= shadow_bank;
         end else if (op_i == cstk_pkg::OP_RET_LIT) begin
            working_register <= literal_i;
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_WORKING_REGISTER) begin
            working_register <= wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         status_o      <= cstk_pkg::RST_ZERO;
         status_load_o <= 1'b0;
      end else if (en_i) begin
         status_load_o <= (state == cstk_pkg::CSTK_RUN)
                       && (op_i == cstk_pkg::OP_RETURN_FROM_INTERRUPT_F || op_i == cstk_pkg::OP_RET_FAST);
         status_o      <= shadow_status;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         table_pointer <= 22'h000000;
      end else if (sel_wr) begin
         if (full_addr == cstk_pkg::ADDR_TBL_LOW) begin
            table_pointer[7:0] <= wdata_i;
         end else if (full_addr == cstk_pkg::ADDR_TBL_HIGH) begin
            table_pointer[15:8] <= wdata_i;
         end else if (full_addr == cstk_pkg::ADDR_TBL_UPPER) begin
            table_pointer[21:16] <= wdata_i[cstk_pkg::TBL_BIT21:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         table_latch <= cstk_pkg::RST_ZERO;
      end else if (en_i && state == cstk_pkg::CSTK_RUN) begin
         if (op_i == cstk_pkg::OP_TBL_READ) begin
            table_latch <= table_pointer[0] ? pmem_word_i[15:8] : pmem_word_i[7:0];
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_TBL_LATCH) begin
            table_latch <= wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pmem_addr_o <= 22'h000000;
         pc_o        <= 21'h000000;
      end else if (en_i) begin
         pmem_addr_o <= table_pointer;
         pc_o        <= pc;
      end
   end

   // Pointer 0 with its indirect side effects
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         data_pointer0 <= 12'h000;
      end else if (en_i && (rd_i || wr_i)) begin
         if (full_addr == cstk_pkg::ADDR_INDIRECT_POST_INCREMENT_0 || full_addr == cstk_pkg::ADDR_INDIRECT_PRE_INCREMENT_0) begin
            data_pointer0 <= data_pointer0 + 12'h001;
         end else if (full_addr == cstk_pkg::ADDR_INDIRECT_POST_DECREMENT_0) begin
            data_pointer0 <= data_pointer0 - 12'h001;
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_PTR0_LOW) begin
            data_pointer0[7:0] <= wdata_i;
         end else if (sel_wr && full_addr == cstk_pkg::ADDR_PTR0_HIGH) begin
            data_pointer0[11:8] <= wdata_i[3:0];
         end
      end
   end

   always_comb begin
      next_data_addr = full_addr;
      case (full_addr)
         cstk_pkg::ADDR_INDIRECT_ACCESS_PTR0, cstk_pkg::ADDR_INDIRECT_POST_INCREMENT_0,
         cstk_pkg::ADDR_INDIRECT_POST_DECREMENT_0: next_data_addr = data_pointer0;
         cstk_pkg::ADDR_INDIRECT_PRE_INCREMENT_0:  next_data_addr = data_pointer0 + 12'h001;
         cstk_pkg::ADDR_INDIRECT_OFFSET_BY_W_0:
            next_data_addr = data_pointer0 + {{4{working_register[7]}}, working_register};
         default: next_data_addr = full_addr;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         data_addr_o <= 12'h000;
      end else if (en_i) begin
         data_addr_o <= next_data_addr;
      end
   end

   // Interrupt control and product bytes are plain storage here
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         intctl[0] <= cstk_pkg::RST_INTCTL3;
         intctl[1] <= cstk_pkg::RST_INTCTL2;
         intctl[2] <= cstk_pkg::RST_ZERO;
         prod[0]   <= cstk_pkg::RST_ZERO;
         prod[1]   <= cstk_pkg::RST_ZERO;
      end else if (sel_wr) begin
         case (full_addr)
            cstk_pkg::ADDR_INTCTL3:   intctl[0] <= wdata_i;
            cstk_pkg::ADDR_INTCTL2:   intctl[1] <= wdata_i;
            cstk_pkg::ADDR_INTCTL1:   intctl[2] <= wdata_i;
            cstk_pkg::ADDR_PROD_LOW:  prod[0]   <= wdata_i;
            cstk_pkg::ADDR_PROD_HIGH: prod[1]   <= wdata_i;
            default: ;
         endcase
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      case (full_addr)
         cstk_pkg::ADDR_WORKING_REGISTER:      next_rdata = working_register;
         cstk_pkg::ADDR_PTR0_LOW:  next_rdata = data_pointer0[7:0];
         cstk_pkg::ADDR_PTR0_HIGH: next_rdata = {4'h0, data_pointer0[11:8]};
         cstk_pkg::ADDR_INTCTL3:   next_rdata = intctl[0];
         cstk_pkg::ADDR_INTCTL2:   next_rdata = intctl[1];
         cstk_pkg::ADDR_INTCTL1:   next_rdata = intctl[2];
         cstk_pkg::ADDR_PROD_LOW:  next_rdata = prod[0];
         cstk_pkg::ADDR_PROD_HIGH: next_rdata = prod[1];
         cstk_pkg::ADDR_TBL_LATCH: next_rdata = table_latch;
         cstk_pkg::ADDR_TBL_LOW:   next_rdata = table_pointer[7:0];
         cstk_pkg::ADDR_TBL_HIGH:  next_rdata = table_pointer[15:8];
         cstk_pkg::ADDR_TBL_UPPER: next_rdata = {2'b00, table_pointer[21:16]};
         cstk_pkg::ADDR_PC_LOW:    next_rdata = pc[7:0];
         cstk_pkg::ADDR_PC_HOLD_H: next_rdata = pc_high_holding;
         cstk_pkg::ADDR_PC_HOLD_U: next_rdata = {3'b000, pc_upper_holding};
         cstk_pkg::ADDR_STK_PTR:
            next_rdata = {stack_full_flag, stack_underflow_flag, 1'b0, return_stack_pointer};
         cstk_pkg::ADDR_TOS_LOW:   next_rdata = top_of_stack[7:0];
         cstk_pkg::ADDR_TOS_HIGH:  next_rdata = top_of_stack[15:8];
         cstk_pkg::ADDR_TOS_UPPER: next_rdata = {3'b000, top_of_stack[20:16]};
         default:                  next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else if (en_i && rd_i) begin
         rdata_o <= next_rdata;
      end
   end
endmodule // cstk_core

/* File: testbench/cstk_core_asserts.sv */
module cstk_core_chk (
   input wire logic        clk_i,
   input wire logic        nrst_i,
   input wire logic        en_i,
   input wire logic        stack_overflow_reset_enable_i,
   input wire logic [3:0]  op_i,
   input wire logic [20:0] target_i,
   input wire logic        rd_i,
   input wire logic        wr_i,
   input wire logic [7:0]  addr_i,
   input wire logic        access_i,
   input wire logic [7:0]  wdata_i,
   input wire logic [20:0] pc_o,
   input wire logic [21:0] pmem_addr_o,
   input wire logic        status_load_o,
   input wire logic [11:0] data_addr_o,
   input wire logic        device_reset_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_vector_pc;
      en_i && op_i == cstk_pkg::OP_VECTOR |=> ##1 pc_o == $past(target_i, 2);
   endproperty
   a_vector_pc: assert property (p_vector_pc) else $error("vector target not taken");
   property p_fast_load;
      en_i && (op_i == 4'h6 || op_i == cstk_pkg::OP_RET_FAST) |=> status_load_o;
   endproperty
   a_fast_load: assert property (p_fast_load) else $error("fast return did not reload");
   property p_plain_hold;
      en_i && (op_i == 4'h5 || op_i == cstk_pkg::OP_RET) |=> !status_load_o;
   endproperty
   a_plain_hold: assert property (p_plain_hold) else $error("plain return reloaded");
   property p_load_cause;
      status_load_o |-> $past(en_i) && ($past(op_i) == 4'h6 || $past(op_i) == 4'h4);
   endproperty
   a_load_cause: assert property (p_load_cause) else $error("shadow reload without cause");
   property p_trip_pulse;
      device_reset_o |=> !device_reset_o ##1 pc_o == 21'h000000;
   endproperty
   a_trip_pulse: assert property (p_trip_pulse) else $error("trip pulse or restart wrong");
   property p_trip_enabled;
      device_reset_o |-> $past(stack_overflow_reset_enable_i, 2);
   endproperty
   a_trip_enabled: assert property (p_trip_enabled) else $error("reset while disabled");
   property p_access_addr;
      en_i && rd_i && access_i && addr_i < 8'hE7 |=>
         data_addr_o == {($past(addr_i) > 8'h5F) ? 4'hF : 4'h0, $past(addr_i)};
   endproperty
   a_access_addr: assert property (p_access_addr) else $error("access bank address wrong");
   property p_pcl_write;
      en_i && wr_i && access_i && addr_i == 8'hF9 && op_i == 4'h0 |=>
         ##1 pc_o[7:0] == $past(wdata_i, 2);
   endproperty
   a_pcl_write: assert property (p_pcl_write) else $error("pc low write lost");
   property p_tblu_write;
      en_i && wr_i && access_i && addr_i == 8'hF8 |=>
         ##1 pmem_addr_o[21:16] == $past(wdata_i[5:0], 2);
   endproperty
   a_tblu_write: assert property (p_tblu_write) else $error("table upper write lost");
endmodule // cstk_core_chk

bind cstk_core cstk_core_chk i_chk (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_i),
   .stack_overflow_reset_enable_i(stack_overflow_reset_enable_i), .op_i(op_i),
   .target_i(target_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .access_i(access_i),
   .wdata_i(wdata_i), .pc_o(pc_o), .pmem_addr_o(pmem_addr_o), .status_load_o(status_load_o),
   .data_addr_o(data_addr_o), .device_reset_o(device_reset_o));

/* File: testbench/cstk_core_tb_top.sv */
module cstk_core_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

   logic        clk_i = 1'b0, nrst_i = 1'b0, por_i = 1'b1, ovr_en = 1'b0;
   logic        rd_i = 1'b0, wr_i = 1'b0;
   logic [3:0]  op_i = 4'h0;
   logic [7:0]  literal_i = 8'h00, status_i = 8'h00, addr_i = 8'h00, wdata_i = 8'h00;
   logic [20:0] target_i = 21'h000000;
   logic [15:0] pmem_word_i = 16'h0000;
   logic [7:0]  rdata_o, status_o;
   logic [20:0] pc_o;
   logic [21:0] pmem_addr_o;
   logic [11:0] data_addr_o;
   logic        status_load_o, device_reset_o;
   int          err_total = 0, total_checks = 0, n;
   logic [7:0]  ra [8] = '{8'hF0, 8'hF1, 8'hF5, 8'hF7, 8'hF8, 8'hF9, 8'hFC, 8'hFE};
   logic [7:0]  rv [8] = '{8'hC0, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   always #12.5 clk_i = ~clk_i;

   cstk_core i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .por_i(por_i),
      .stack_overflow_reset_enable_i(ovr_en), .op_i(op_i), .literal_i(literal_i),
      .target_i(target_i), .status_i(status_i), .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i),
      .access_i(1'b1), .wdata_i(wdata_i), .pmem_word_i(pmem_word_i), .rdata_o(rdata_o),
      .pc_o(pc_o), .pmem_addr_o(pmem_addr_o), .status_o(status_o),
      .status_load_o(status_load_o), .data_addr_o(data_addr_o),
      .device_reset_o(device_reset_o));

   task automatic cyc();
      @(posedge clk_i);
      #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      op_i = cstk_pkg::OP_NONE;
      rd_i = 1'b0;
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      cyc();
   endtask
   task automatic rd(input logic [7:0] a);
      op_i = cstk_pkg::OP_NONE;
      wr_i = 1'b0;
      addr_i = a;
      rd_i = 1'b1;
      cyc();
   endtask
   // Strobes stay up between like calls; this drops them for one edge
   task automatic idle();
      op_i = cstk_pkg::OP_NONE;
      rd_i = 1'b0;
      wr_i = 1'b0;
      cyc();
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      rd(a);
      `CHK(nm, e, rdata_o)
   endtask
   task automatic op(input logic [3:0] o, input logic [7:0] st);
      rd_i = 1'b0;
      wr_i = 1'b0;
      op_i = o;
      status_i = st;
      cyc();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      #2;
      nrst_i = 1'b1;
      por_i = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rchk(ra[i], rv[i], "reset value");
      end
      $display("test reset values done");
      // Second vector lands on top of the first
      wr(8'hE8, 8'h11);
      target_i = 21'h000100;
      op(cstk_pkg::OP_VECTOR, 8'hA5);
      // Program counter output trails the internal counter by one edge
      idle();
      `CHK("vector pc", 21'h000100, pc_o)
      wr(8'hE8, 8'h22);
      target_i = 21'h000008;
      op(cstk_pkg::OP_VECTOR, 8'h3C);
      wr(8'hE8, 8'h99);
      op(4'h6, 8'h00);
      `CHK("shadow load", 1'b1, status_load_o)
      `CHK("shadow status", 8'h3C, status_o)
      rchk(8'hE8, 8'h22, "restored w");
      op(4'h5, 8'h00);
      `CHK("plain load", 1'b0, status_load_o)
      rchk(8'hE8, 8'h22, "kept w");
      wr(8'hE8, 8'h44);
      target_i = 21'h000200;
      op(cstk_pkg::OP_CALL_FAST, 8'h77);
      wr(8'hE8, 8'h55);
      op(cstk_pkg::OP_RET_FAST, 8'h00);
      `CHK("fast call status", 8'h77, status_o)
      rchk(8'hE8, 8'h44, "fast call w");
      $display("test shadow store done");
      wr(8'hE8, 8'h04);
      target_i = 21'h000300;
      op(cstk_pkg::OP_CALL, 8'h00);
      rchk(8'hFC, 8'h01, "depth in table");
      rchk(8'hFF, 8'h00, "stack upper");
      wr(8'hF9, 8'h10);
      op(4'h8, 8'h00);
      idle();
      `CHK("computed jump", 8'h14, pc_o[7:0])
      literal_i = 8'h5A;
      op(cstk_pkg::OP_RET_LIT, 8'h00);
      rchk(8'hE8, 8'h5A, "literal w");
      rchk(8'hFC, 8'h00, "depth after");
      $display("test computed jump done");
      wr(8'hF8, 8'hFF);
      rchk(8'hF8, 8'h3F, "pointer upper");
      wr(8'hF8, 8'h00);
      wr(8'hF7, 8'h12);
      wr(8'hF6, 8'h35);
      idle();
      `CHK("table address", 22'h001235, pmem_addr_o)
      pmem_word_i = 16'hBEEF;
      op(cstk_pkg::OP_TBL_READ, 8'h00);
      rchk(8'hF5, 8'hBE, "odd byte");
      wr(8'hF6, 8'h34);
      op(cstk_pkg::OP_TBL_READ, 8'h00);
      rchk(8'hF5, 8'hEF, "even byte");
      $display("test table read done");
      wr(8'hE9, 8'h20);
      wr(8'hEA, 8'h03);
      wr(8'hE8, 8'hF0);
      rd(8'hEB);
      `CHK("offset address", 12'h310, data_addr_o)
      rchk(8'hE9, 8'h20, "pointer kept");
      rd(8'h60);
      `CHK("access address", 12'hF60, data_addr_o)
      rd(8'h20);
      `CHK("access low address", 12'h020, data_addr_o)
      $display("test indirect done");
      target_i = 21'h000000;
      repeat (32) op(cstk_pkg::OP_CALL, 8'h00);
      rchk(8'hFC, 8'h9F, "full flag");
      `CHK("no trip", 1'b0, device_reset_o)
      wr(8'hFC, 8'h1F);
      rchk(8'hFC, 8'h1F, "flag cleared");
      op(cstk_pkg::OP_CALL, 8'h00);
      idle();
      nrst_i = 1'b0;
      cyc();
      nrst_i = 1'b1;
      rchk(8'hFC, 8'h80, "flag survives");
      por_i = 1'b1;
      nrst_i = 1'b0;
      cyc();
      nrst_i = 1'b1;
      por_i = 1'b0;
      rchk(8'hFC, 8'h00, "power-on clear");
      ovr_en = 1'b1;
      op(cstk_pkg::OP_RET, 8'h00);
      n = 1;
      while (device_reset_o !== 1'b1 && n < 8) begin
         cyc();
         n++;
      end
      `CHK("trip delay", 2, n)
      cyc();
      rchk(8'hFC, 8'h40, "underflow flag");
      ovr_en = 1'b0;
      $display("test stack limits done");
      tally_and_finish();
   end
endmodule // cstk_core_tb_top
